//--- logic/uart_irda_defs.svh
// Offsets, field positions, reset values and timing counts of the serial pin and infrared block.
`ifndef UART_IRDA_DEFS_SVH
`define UART_IRDA_DEFS_SVH

// ==========================================================================
// Register byte addresses
`define ADDR_INFRARED_CLOCK_DIVIDER 32'h4000_40e0
`define ADDR_SERIAL_PIN_INFRARED_CONTROL 32'h4005_4000
`define ADDR_SERIAL_CLOCK_MODE_STATUS 32'h4005_4004

// ==========================================================================
// Reset values and writable bit masks
`define RESET_INFRARED_CLOCK_DIVIDER 16'h0000
`define RESET_SERIAL_PIN_INFRARED_CONTROL 12'h000
`define RESET_CLOCK_MODE_FIELDS 8'h00
`define MASK_DIVIDER_WRITE 32'h0000_ffff
`define MASK_CONTROL_WRITE 32'h0000_0e3f
`define MASK_MODE_WRITE 32'h0000_0ff0

// ==========================================================================
// Field positions
`define DIV_X_MSB 15
`define DIV_X_LSB 8
`define DIV_Y_MSB 7
`define DIV_Y_LSB 0
`define CONTROL_MSB 11
`define MODE_MSB 11
`define MODE_LSB 4
`define STATUS_FIELD_MSB 22
`define STATUS_FIELD_LSB 16
`define STATUS_ANY_BIT 14

// ==========================================================================
// Pulse timing in ticks of the sixteen-times bit clock
`define TICKS_PER_BIT 5'h10
`define PULSE_TICKS 4'h3
`define LAST_BIT_TICK 4'hf

// ==========================================================================
// Pin synchroniser idle levels: usb minus, port five rx, infrared rx, peripheral clock
`define SYNC_RESET 4'he

// ==========================================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

//--- logic/uart_irda_pkg.sv
// Types shared by the serial pin and infrared control block.
package uart_irda_pkg;

	// Control register fields, bit 11 down to bit 0.
	typedef struct packed {
		logic port3_modem_pin_enable;
		logic echo_rx_extra_invert;
		logic echo_rx_mask_enable;
		logic [2:0] reserved;
		logic infrared_codec_bypass;
		logic infrared_tx_invert;
		logic infrared_rx_invert;
		logic rx_pulse_length_select;
		logic tx_pulse_length_select;
		logic port5_usb_pin_route;
	} ctrl_t;

	// Fractional divider ratio, X in the upper byte.
	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
	} divider_t;

	// Per-port clock mode encoding in declaration order 00, 01, 10, 11.
	typedef enum logic [1:0] {
		clock_off,
		clock_on,
		clock_auto,
		clock_unused
	} clock_mode_t;

	// Receive demodulator states.
	typedef enum logic {
		demod_idle,
		demod_hold
	} demod_state_t;

endpackage

//--- logic/frac_divider.sv
// Fractional X/Y accumulator divider producing one tick per wrap.
`timescale 1ns/10ps
`default_nettype none

module frac_divider (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step,
	input wire uart_irda_pkg::divider_t ratio,
	output logic tick,
	output logic stopped
);
	import uart_irda_pkg::*;

	logic [7:0] acc;

	// A zero in either field parks the accumulator and silences the output.
	wire halt = (ratio.x == 8'h00) || (ratio.y == 8'h00);
	wire [8:0] sum = {1'b0, acc} + {1'b0, ratio.x};
	wire wrap = sum >= {1'b0, ratio.y};
	wire [8:0] next_sum = wrap ? sum - {1'b0, ratio.y} : sum;

	// Add X on every input cycle modulo Y; a wrap is one output tick.
	always_ff @(posedge aclk) begin
		if (!aresetn || halt) begin
			acc <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (step) begin
				acc <= next_sum[7:0];
				tick <= wrap;
			end
		end
	end

	// Low-power indication follows the halt condition one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stopped <= 1'b1;
		end else begin
			stopped <= halt;
		end
	end

endmodule

`default_nettype wire

//--- logic/uart_irda_clock_pin_control.sv
// Serial pin routing, infrared codec for port six, infrared clock divider and clock status.
//
// Function
// - Infrared clock is peripheral clock times X/Y, X bits 15:8, Y bits 7:0.
// - A zero X or Y stops the infrared clock and idles the divider.
// - Divided clock drives the infrared codec only in fixed 115.2 kbps pulse mode.
// - Control bit 11 enables port three modem pins.
// - Control bit 10 inverts infrared receive again, on top of bit 3.
// - Control bit 9 masks infrared receive while port six transmit is low.
// - Control bit 5 clear uses the infrared codec, set bypasses it.
// - Control bit 4 inverts the infrared transmit pin.
// - Control bit 3 inverts the infrared receive pin.
// - Control bit 2 picks receive pulse width: bit period or fixed 115.2 kbps.
// - Control bit 1 picks transmit pulse width: bit period or fixed 115.2 kbps.
// - Control bit 0 also routes port five transmit and receive onto USB pins.
// - Status bits 22:16 show each port clock running, port n at bit n-1.
// - Status bit 14 reads one while any port clock runs, else zero.
// - Clock mode fields encode 00 off, 01 on, 10 automatic, 11 unused.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "uart_irda_defs.svh"

module uart_irda_clock_pin_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic peripheral_source_clock,
	output logic infrared_clock_tick,
	output logic infrared_clock_stopped,
	input wire logic port_six_tx,
	input wire logic port_six_baud16_tick,
	output logic port_six_rx,
	output logic infrared_tx_pin,
	input wire logic infrared_rx_pin,
	input wire logic port_five_tx,
	input wire logic port_five_rx_pin,
	output logic port_five_rx,
	output logic usb_dplus_out,
	output logic usb_dplus_oe_n,
	input wire logic usb_dminus_pin,
	output logic port3_modem_pin_enable,
	input wire logic [3:0] auto_clock_request,
	input wire logic [2:0] fast_port_clock_running,
	output logic [3:0] port_clock_enable
);
	import uart_irda_pkg::*;

	// ======================================================================
	// Helper functions

	// Merges write data into a register under byte strobes and a writable mask.
	function automatic logic [31:0] merge_write(input logic [31:0] old_value,
			input logic [31:0] data, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge_write = ((old_value & ~lanes) | (data & lanes)) & mask;
	endfunction

	// Tells whether a standard port's clock runs in its mode.
	function automatic logic port_running(input clock_mode_t mode, input logic request);
		port_running = (mode == clock_on) || ((mode == clock_auto) && request);
	endfunction

	// ======================================================================
	// Registers and state

	divider_t divider;
	ctrl_t ctrl;
	logic [7:0] mode_bits;
	logic [6:0] clock_status;
	logic any_clock_running;
	logic aw_held;
	logic w_held;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] sync_c;
	logic [3:0] pin_level;
	logic periph_prev;
	logic [3:0] tx_phase;
	logic [3:0] rx_count;
	demod_state_t demod_state;
	demod_state_t next_demod_state;

	// ======================================================================
	// Address decode and read mux

	wire wr_div = wr_addr == `ADDR_INFRARED_CLOCK_DIVIDER;
	wire wr_ctrl = wr_addr == `ADDR_SERIAL_PIN_INFRARED_CONTROL;
	wire wr_mode = wr_addr == `ADDR_SERIAL_CLOCK_MODE_STATUS;
	wire wr_hit = wr_div || wr_ctrl || wr_mode;
	wire wr_go = aw_held && w_held && !bvalid;
	wire rd_div = araddr == `ADDR_INFRARED_CLOCK_DIVIDER;
	wire rd_ctrl = araddr == `ADDR_SERIAL_PIN_INFRARED_CONTROL;
	wire rd_mode = araddr == `ADDR_SERIAL_CLOCK_MODE_STATUS;
	wire rd_hit = rd_div || rd_ctrl || rd_mode;
	wire [31:0] div_word = {16'h0000, divider};
	wire [31:0] ctrl_word = {20'h0_0000, ctrl};
	wire [31:0] mode_word = {9'h000, clock_status, 1'b0, any_clock_running, 2'h0,
		mode_bits, 4'h0};
	wire [31:0] rd_value = rd_div ? div_word : rd_ctrl ? ctrl_word : rd_mode ? mode_word :
		32'h0000_0000;
	wire [31:0] div_merged = merge_write(div_word, wr_data, wr_strb, `MASK_DIVIDER_WRITE);
	wire [31:0] ctrl_merged = merge_write(ctrl_word, wr_data, wr_strb, `MASK_CONTROL_WRITE);
	wire [31:0] mode_merged = merge_write(mode_word, wr_data, wr_strb, `MASK_MODE_WRITE);

	// ======================================================================
	// AXI4-Lite write channels: address and data are taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 32'h0000_0000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Write response follows once both halves are held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Software registers; reserved control bits are stored as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divider <= `RESET_INFRARED_CLOCK_DIVIDER;
			ctrl <= `RESET_SERIAL_PIN_INFRARED_CONTROL;
			mode_bits <= `RESET_CLOCK_MODE_FIELDS;
		end else if (wr_go) begin
			if (wr_div) begin
				divider <= div_merged[`DIV_X_MSB:`DIV_Y_LSB];
			end
			if (wr_ctrl) begin
				ctrl <= ctrl_merged[`CONTROL_MSB:0];
			end
			if (wr_mode) begin
				mode_bits <= mode_merged[`MODE_MSB:`MODE_LSB];
			end
		end
	end

	// ======================================================================
	// AXI4-Lite read channel: one cycle from address to data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_value;
			rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ======================================================================
	// Pin synchronisers: a level is accepted once stages two and three agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= `SYNC_RESET;
			sync_b <= `SYNC_RESET;
			sync_c <= `SYNC_RESET;
			pin_level <= `SYNC_RESET;
		end else begin
			sync_a <= {usb_dminus_pin, port_five_rx_pin, infrared_rx_pin,
				peripheral_source_clock};
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_level <= (sync_b & ~(sync_b ^ sync_c)) | (pin_level & (sync_b ^ sync_c));
		end
	end

	// Each rising edge of the peripheral clock is one divider input cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_prev <= 1'b0;
		end else begin
			periph_prev <= pin_level[0];
		end
	end

	wire periph_step = pin_level[0] && !periph_prev;

	// ======================================================================
	// Infrared clock divider.
	frac_divider divider_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.step(periph_step),
		.ratio(divider),
		.tick(infrared_clock_tick),
		.stopped(infrared_clock_stopped)
	);

	// The divided clock only paces a direction set to fixed-rate pulses.
	wire tx_tick = ctrl.tx_pulse_length_select ? infrared_clock_tick
		: port_six_baud16_tick;
	wire rx_tick = ctrl.rx_pulse_length_select ? infrared_clock_tick
		: port_six_baud16_tick;

	// ======================================================================
	// Transmit modulator: a three-tick pulse at the start of each low bit.
	always_ff @(posedge aclk) begin
		if (!aresetn || port_six_tx) begin
			tx_phase <= 4'h0;
		end else if (tx_tick) begin
			tx_phase <= tx_phase + 4'h1;
		end
	end

	wire tx_pulse = !port_six_tx && (tx_phase < `PULSE_TICKS);
	wire tx_line = ctrl.infrared_codec_bypass ? port_six_tx : tx_pulse;

	// Transmit pin with optional inversion.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			infrared_tx_pin <= 1'b0;
		end else begin
			infrared_tx_pin <= tx_line ^ ctrl.infrared_tx_invert;
		end
	end

	// ======================================================================
	// Receive path: two stacked inversions, echo mask, then demodulation.
	wire rx_level = pin_level[1] ^ ctrl.infrared_rx_invert ^ ctrl.echo_rx_extra_invert;
	wire rx_masked = ctrl.echo_rx_mask_enable && !port_six_tx;
	wire rx_pulse = !rx_level && !rx_masked;
	wire hold_done = rx_tick && (rx_count == `LAST_BIT_TICK);

	// A received pulse holds the port's receive line low for one bit.
	always_comb begin
		next_demod_state = demod_state;
		case (demod_state)
			demod_idle: begin
				if (rx_pulse) begin
					next_demod_state = demod_hold;
				end
			end
			demod_hold: begin
				if (hold_done) begin
					next_demod_state = demod_idle;
				end
			end
			default: begin
				next_demod_state = demod_idle;
			end
		endcase
	end

	// Demodulator state and bit-length counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			demod_state <= demod_idle;
			rx_count <= 4'h0;
		end else begin
			demod_state <= next_demod_state;
			if (demod_state == demod_idle) begin
				rx_count <= 4'h0;
			end else if (rx_tick) begin
				rx_count <= rx_count + 4'h1;
			end
		end
	end

	wire codec_rx = !((demod_state == demod_hold) || rx_pulse);
	wire bypass_rx = rx_masked ? 1'b1 : rx_level;

	// Receive line towards port six, idle high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_six_rx <= 1'b1;
		end else begin
			port_six_rx <= ctrl.infrared_codec_bypass ? bypass_rx : codec_rx;
		end
	end

	// ======================================================================
	// Port five USB routing and port three modem pins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			usb_dplus_out <= 1'b1;
			usb_dplus_oe_n <= 1'b1;
			port_five_rx <= 1'b1;
			port3_modem_pin_enable <= 1'b0;
		end else begin
			usb_dplus_out <= port_five_tx;
			usb_dplus_oe_n <= !ctrl.port5_usb_pin_route;
			port_five_rx <= pin_level[2] && (pin_level[3] || !ctrl.port5_usb_pin_route);
			port3_modem_pin_enable <= ctrl.port3_modem_pin_enable;
		end
	end

	// ======================================================================
	// Clock enables and status: ports 1, 2 and 7 report their own state.
	wire [3:0] std_running = {
		port_running(clock_mode_t'(mode_bits[7:6]), auto_clock_request[3]),
		port_running(clock_mode_t'(mode_bits[5:4]), auto_clock_request[2]),
		port_running(clock_mode_t'(mode_bits[3:2]), auto_clock_request[1]),
		port_running(clock_mode_t'(mode_bits[1:0]), auto_clock_request[0])};
	wire [6:0] next_status = {fast_port_clock_running[2], std_running,
		fast_port_clock_running[1:0]};

	// Status refreshes every cycle, so a read sees at most one cycle of lag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_status <= 7'h00;
			any_clock_running <= 1'b0;
			port_clock_enable <= 4'h0;
		end else begin
			clock_status <= next_status;
			any_clock_running <= |next_status;
			port_clock_enable <= std_running;
		end
	end

endmodule

`default_nettype wire

//--- logic/empty_placeholder_removed.sv
// Intentionally minimal: no module content.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- verif/uart_irda_sva.sv
// Checker of bus answers, divider ticks and pin routing of the serial pin block.
`timescale 1ns/10ps
`default_nettype none

module uart_irda_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic infrared_clock_tick,
	input wire logic infrared_clock_stopped,
	input wire logic port_five_tx,
	input wire logic usb_dplus_out,
	input wire logic usb_dplus_oe_n,
	input wire logic port3_modem_pin_enable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================================
	// Bus answers come in time and stand until taken.
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer missing");
	write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");

	// Divider ticks are single pulses and cease while a field is zero.
	tick_single_a: assert property (infrared_clock_tick |=> !infrared_clock_tick)
		else $error("tick longer than a cycle");
	stop_quiet_a: assert property (infrared_clock_stopped && $past(infrared_clock_stopped) |-> !infrared_clock_tick)
		else $error("tick while stopped");

	// Pin controls move only as a register write completes; the USB plus line follows port five transmit.
	modem_after_write_a: assert property ($changed(port3_modem_pin_enable) |-> !$past(awready))
		else $error("modem enable moved without write");
	route_after_write_a: assert property ($changed(usb_dplus_oe_n) |-> !$past(awready))
		else $error("usb route moved without write");
	usb_follow_a: assert property (!usb_dplus_oe_n && !$past(usb_dplus_oe_n) |-> usb_dplus_out == $past(port_five_tx))
		else $error("usb plus line not following port five");

	cover property (infrared_clock_tick);
	cover property (bvalid && bready && bresp == 2'h3);
	cover property (!usb_dplus_oe_n);
endmodule

bind uart_irda_clock_pin_control uart_irda_sva uart_irda_sva_i (.*);

`default_nettype wire

//--- verif/ir_transceiver_model.sv
// Behavioural infrared transceiver facing the port six pins.
`timescale 1ns/10ps
`default_nettype none

module ir_transceiver_model (
	input wire logic aclk,
	input wire logic flash_fire,
	input wire logic [7:0] flash_len,
	input wire logic echo_on,
	input wire logic infrared_tx_pin,
	output logic infrared_rx_pin
);
	logic [7:0] left = 8'h0;

	// Counts down the cycles of a light flash arriving from far away.
	always @(posedge aclk) begin
		if (flash_fire)
			left <= flash_len;
		else if (left != 8'h0)
			left <= left - 8'h1;
	end

	// The receiver pulls low while light falls on it, its own reflected light included.
	assign infrared_rx_pin = !(left != 8'h0 || (echo_on && infrared_tx_pin === 1'h1));
endmodule

`default_nettype wire

//--- verif/uart_irda_clock_pin_control_bench.sv
// Self-checking bench of the serial pin and infrared control block.
`timescale 1ns/10ps
`default_nettype none
`include "uart_irda_defs.svh"

module uart_irda_clock_pin_control_bench;
	import uart_irda_pkg::*;
	localparam logic [31:0] div_addr = `ADDR_INFRARED_CLOCK_DIVIDER;
	localparam logic [31:0] ctrl_addr = `ADDR_SERIAL_PIN_INFRARED_CONTROL;
	localparam logic [31:0] mode_addr = `ADDR_SERIAL_CLOCK_MODE_STATUS;
	localparam logic [1:0] okay = `RESP_OKAY;
	localparam logic [1:0] decerr = `RESP_DECERR;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, peripheral_source_clock = 1'h0, port_six_tx = 1'h1;
	logic port_six_baud16_tick = 1'h1, port_five_tx = 1'h1, port_five_rx_pin = 1'h1;
	logic usb_dminus_pin = 1'h1, flash_fire = 1'h0, echo_on = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0, fast_port_clock_running = 3'h0;
	logic [3:0] wstrb = 4'hf, auto_clock_request = 4'h0;
	logic [7:0] flash_len = 8'h0;
	logic awready, wready, bvalid, arready, rvalid, infrared_clock_tick, infrared_clock_stopped;
	logic port_six_rx, infrared_tx_pin, infrared_rx_pin, port_five_rx, usb_dplus_out;
	logic usb_dplus_oe_n, port3_modem_pin_enable;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] port_clock_enable;
	int miscompares = 0, total_checks = 0, ticks = 0;

	uart_irda_clock_pin_control uart_irda_clock_pin_control_i (.*);
	ir_transceiver_model ir_transceiver_model_i (.*);

	// ==========================================================================
	// Clock at 200 MHz and a count of divider ticks.
	initial begin
		forever #2.5 aclk = !aclk;
	end
	always @(posedge aclk) begin
		if (infrared_clock_tick === 1'h1)
			ticks <= ticks + 1;
	end

	// ==========================================================================
	// Shared helpers for waiting, comparing and ending the run.
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic give_up;
		miscompares++;
		$display("wrong value at %0t: bus answer never came", $time);
		final_report;
	endtask

	// Register write and read on the bus, each holding its valid until taken.
	// The answer is accepted one cycle after it shows, so the slave must hold it.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'h1;
		end
		bready <= 1'h0;
		if (n == 40) give_up;
		check({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'h1;
		end
		rready <= 1'h0;
		if (n == 40) give_up;
		check(rdata, exp);
		check({30'h0, rresp}, {30'h0, er});
	endtask

	// Sixteen peripheral clock edges through the divider, ticks counted.
	task automatic div_run(input logic [15:0] xy, input int exp);
		int start;
		wr(div_addr, {16'h0, xy}, okay);
		cyc(4);
		check({31'h0, infrared_clock_stopped}, {31'h0, xy[15:8] == 8'h0 || xy[7:0] == 8'h0});
		start = ticks;
		for (int k = 0; k < 128; k++) begin
			@(posedge aclk);
			peripheral_source_clock <= k[2];
		end
		cyc(12);
		check(ticks - start, exp);
	endtask

	// One low bit of 16 cycles sent; cycles with the pin at the given level counted.
	task automatic tx_run(input logic [11:0] c, input logic lvl, input int exp);
		int n;
		wr(ctrl_addr, {20'h0, c}, okay);
		cyc(24);
		n = 0;
		for (int k = 0; k < 24; k++) begin
			@(posedge aclk);
			port_six_tx <= k >= 16;
			if (infrared_tx_pin === lvl) n++;
		end
		check(n, exp);
	endtask

	// A flash or an own echo offered; low cycles of the receive line counted.
	task automatic rx_run(input logic [11:0] c, input logic tx_low, input logic [7:0] len,
			input int lo, input int hi);
		int n;
		wr(ctrl_addr, {20'h0, c}, okay);
		cyc(24);
		n = 0;
		echo_on <= tx_low;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			flash_fire <= k == 0;
			flash_len <= len;
			port_six_tx <= !(tx_low && k < 16);
			if (port_six_rx === 1'h0) n++;
		end
		echo_on <= 1'h0;
		check({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	// ==========================================================================
	// Main sequence.
	initial begin
		cyc(16);
		aresetn <= 1'h1;
		cyc(4);
		rd(div_addr, 32'h0, okay);
		rd(ctrl_addr, 32'h0, okay);
		rd(mode_addr, 32'h0, okay);
		rd(32'h4005_4008, 32'h0, decerr);
		wr(32'h4005_4008, 32'hffff_ffff, decerr);
		wr(ctrl_addr, 32'hffff_ffff, okay);
		rd(ctrl_addr, 32'he3f, okay);
		check({30'h0, port3_modem_pin_enable, usb_dplus_oe_n}, 32'h2);
		wr(ctrl_addr, 32'h1, okay);
		usb_dminus_pin <= 1'h0;
		port_five_tx <= 1'h0;
		cyc(8);
		check({29'h0, port3_modem_pin_enable, port_five_rx, usb_dplus_out}, 32'h0);
		wr(ctrl_addr, 32'h0, okay);
		cyc(8);
		check({30'h0, port_five_rx, usb_dplus_oe_n}, 32'h3);
		usb_dminus_pin <= 1'h1;
		port_five_tx <= 1'h1;
		fast_port_clock_running <= 3'h5;
		auto_clock_request <= 4'h2;
		wr(mode_addr, 32'hc90, okay);
		rd(mode_addr, 32'h4d_4c90, okay);
		check({28'h0, port_clock_enable}, 32'h3);
		fast_port_clock_running <= 3'h0;
		auto_clock_request <= 4'h0;
		rd(mode_addr, 32'h4_4c90, okay);
		wr(mode_addr, 32'hffff_ffff, okay);
		rd(mode_addr, 32'hff0, okay);
		wr(mode_addr, 32'h550, okay);
		rd(mode_addr, 32'h3c_4550, okay);
		wr(mode_addr, 32'h0, okay);
		rd(mode_addr, 32'h0, okay);
		wr(div_addr, 32'hffff_ffff, okay);
		rd(div_addr, 32'hffff, okay);
		wstrb <= 4'h2;
		wr(div_addr, 32'h0, okay);
		wstrb <= 4'hf;
		rd(div_addr, 32'hff, okay);
		div_run(16'h0102, 8);
		div_run(16'h0304, 12);
		div_run(16'h0505, 16);
		div_run(16'h0004, 0);
		div_run(16'h0300, 0);
		tx_run(12'h000, 1'h1, 3);
		tx_run(12'h010, 1'h0, 3);
		tx_run(12'h020, 1'h0, 16);
		tx_run(12'h030, 1'h1, 16);
		tx_run(12'h002, 1'h1, 16);
		rx_run(12'h000, 1'h0, 8'h3, 16, 18);
		rx_run(12'h000, 1'h1, 8'h0, 16, 18);
		rx_run(12'h200, 1'h1, 8'h0, 0, 0);
		rx_run(12'h008, 1'h0, 8'h0, 40, 40);
		rx_run(12'h408, 1'h0, 8'h0, 0, 0);
		rx_run(12'h020, 1'h0, 8'h3, 3, 3);
		rx_run(12'h004, 1'h0, 8'h3, 30, 40);
		rx_run(12'h000, 1'h0, 8'h0, 0, 0);
		final_report;
	end
endmodule

`default_nettype wire
